// ==== rtl/tlb_ctl_pkg.sv ====
/*
 * Constants for the TLB inhibit-enable and wired-boundary control block:
 * coprocessor register numbers and selects, field positions, reset values
 * and exception codes.
 * Assumes the coprocessor register port of the core addresses registers
 * by a 5-bit number and a 3-bit select.
 */
package tlb_ctl_pkg;
    // coprocessor register numbers and selects
    localparam logic [4:0] INH_REG_NUM    = 5'h05;
    localparam logic [2:0] INH_REG_SEL    = 3'h1;
    localparam logic [4:0] WIRED_REG_NUM  = 5'h06;
    localparam logic [2:0] WIRED_REG_SEL  = 3'h0;
    localparam logic [4:0] RANDOM_REG_NUM = 5'h01;
    localparam logic [2:0] RANDOM_REG_SEL = 3'h0;
    localparam logic [4:0] CFG1_REG_NUM   = 5'h10;
    localparam logic [2:0] CFG1_REG_SEL   = 3'h1;

    // inhibit-enable register fields
    localparam int RIE_BIT = 31;
    localparam int XIE_BIT = 30;
    localparam int IEC_BIT = 27;
    localparam logic RIE_RST = 1'b0;
    localparam logic XIE_RST = 1'b0;
    localparam logic IEC_RST = 1'b0;

    // wired-boundary field
    localparam int WIRED_MSB = 4;
    localparam logic [4:0] WIRED_RST = 5'h00;

    // entry-low inhibit bit positions
    localparam int ENTRY_RI_BIT = 31;
    localparam int ENTRY_XI_BIT = 30;

    // config one: entry count minus one at bits 30:25
    localparam int CFG1_SIZE_LSB = 25;

    // exception codes
    localparam logic [4:0] TLB_LOAD_EXC_CODE = 5'h02;
    localparam logic [4:0] READ_INH_EXC_CODE = 5'h13;
    localparam logic [4:0] EXEC_INH_EXC_CODE = 5'h14;
endpackage

// ==== rtl/random_index.sv ====
/*
 * Random replacement index counter for the TLB. Decrements every cycle
 * between the top entry and the wired boundary, and wraps back to the top.
 * Assumes the wired boundary arrives from a register on the same clock.
 */
`timescale 1ns/100ps
module random_index #(
    parameter int IDX_W   = 5,
    parameter int ENTRIES = 32
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             rst_b,
    // control
    input  wire logic             reload,
    input  wire logic [IDX_W-1:0] wired,
    // state
    output logic      [IDX_W-1:0] index_ff
);
    localparam logic [IDX_W-1:0] TOP = IDX_W'(ENTRIES - 1);

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            index_ff <= TOP;
        end else if (reload) begin
            index_ff <= TOP;
        end else if (index_ff <= wired || index_ff == '0) begin
            index_ff <= TOP;
        end else begin
            index_ff <= index_ff - 1'b1;
        end
    end
endmodule // random_index

// ==== rtl/tlb_ctl.sv ====
/*
 * Inhibit-enable and wired-boundary control registers of the MMU, with the
 * random replacement index, entry-low inhibit write filtering, inhibit
 * exception code selection and TLB write index selection.
 * Assumes a core-side coprocessor port: write strobe and read address
 * valid on one cycle, read data registered one cycle later.
 */
`timescale 1ns/100ps
//
// Contract
// - Read-inhibit enable (bit 31) lets entry-low read-inhibit work, else it is dropped.
// - Execute-inhibit enable (bit 30) lets entry-low execute-inhibit work, else dropped.
// - Code select (bit 27) gives inhibit faults their own codes, else the load code.
// - Bits 29-28 and 26-0 of the inhibit-enable register read as zero.
// - Random TLB writes never pick an entry below the wired boundary.
// - Indexed TLB writes may target any entry, wired ones included.
// - Reset clears the wired boundary to zero.
// - Any write to the wired boundary reloads the random index to its top.
// - The boundary is bits 4-0 and bits 31-5 read as zero.
// - Boundary N wires entries 0 to N-1 and leaves N and up random.
// - Boundary zero leaves every entry random.
// - The boundary field width follows the TLB size like the index register.
// - The entry count minus one is readable in the six-bit size field of config one.
module tlb_ctl #(
    parameter int ENTRIES = 32,
    parameter int IDX_W   = 5
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             rst_b,
    // coprocessor register access
    input  wire logic             cp_wr,
    input  wire logic             cp_rd,
    input  wire logic [4:0]       cp_num,
    input  wire logic [2:0]       cp_sel,
    input  wire logic [31:0]      cp_wdata,
    output logic      [31:0]      cp_rdata_ff,
    // entry-low write filtering
    input  wire logic             entry_wr,
    input  wire logic [31:0]      entry_wdata,
    output logic      [31:0]      entry_wdata_ff,
    output logic                  entry_wr_ff,
    // inhibit fault reporting
    input  wire logic             ri_fault,
    input  wire logic             xi_fault,
    output logic                  exc_valid_ff,
    output logic      [4:0]       exc_code_ff,
    // TLB write index
    input  wire logic             tlb_write_random_op,
    input  wire logic             tlb_write_indexed_op,
    input  wire logic [IDX_W-1:0] index_reg,
    output logic                  tlb_we_ff,
    output logic      [IDX_W-1:0] tlb_widx_ff,
    // state views
    output logic                  read_inhibit_enable_ff,
    output logic                  execute_inhibit_enable_ff,
    output logic      [IDX_W-1:0] wired_ff
);
    localparam logic [5:0] SIZE_M1 = 6'(ENTRIES - 1);

    logic             iec_ff;
    logic [IDX_W-1:0] random_idx;
    logic             wr_inh;
    logic             wr_wired;
    logic [31:0]      nxt_rdata;
    logic [31:0]      nxt_entry;

    assign wr_inh   = cp_wr && cp_num == tlb_ctl_pkg::INH_REG_NUM
                      && cp_sel == tlb_ctl_pkg::INH_REG_SEL;
    assign wr_wired = cp_wr && cp_num == tlb_ctl_pkg::WIRED_REG_NUM
                      && cp_sel == tlb_ctl_pkg::WIRED_REG_SEL;

    ////////////////////////////////////////////////////////////////////////
    // inhibit-enable register
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            read_inhibit_enable_ff    <= tlb_ctl_pkg::RIE_RST;
            execute_inhibit_enable_ff <= tlb_ctl_pkg::XIE_RST;
            iec_ff                    <= tlb_ctl_pkg::IEC_RST;
        end else if (wr_inh) begin
            read_inhibit_enable_ff    <= cp_wdata[tlb_ctl_pkg::RIE_BIT];
            execute_inhibit_enable_ff <= cp_wdata[tlb_ctl_pkg::XIE_BIT];
            iec_ff                    <= cp_wdata[tlb_ctl_pkg::IEC_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // wired boundary register
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wired_ff <= IDX_W'(tlb_ctl_pkg::WIRED_RST);
        end else if (wr_wired) begin
            wired_ff <= cp_wdata[IDX_W-1:0];
        end
    end

    random_index #(
        .IDX_W   (IDX_W),
        .ENTRIES (ENTRIES)
    ) u_random (
        .mclk     (mclk),
        .rst_b    (rst_b),
        .reload   (wr_wired),
        .wired    (wired_ff),
        .index_ff (random_idx)
    );

    ////////////////////////////////////////////////////////////////////////
    // register read
    always_comb begin
        nxt_rdata = 32'h00000000;
        if (cp_num == tlb_ctl_pkg::INH_REG_NUM
            && cp_sel == tlb_ctl_pkg::INH_REG_SEL) begin
            // unimplemented bits stay zero
            nxt_rdata[tlb_ctl_pkg::RIE_BIT] = read_inhibit_enable_ff;
            nxt_rdata[tlb_ctl_pkg::XIE_BIT] = execute_inhibit_enable_ff;
            nxt_rdata[tlb_ctl_pkg::IEC_BIT] = iec_ff;
        end else if (cp_num == tlb_ctl_pkg::WIRED_REG_NUM
                     && cp_sel == tlb_ctl_pkg::WIRED_REG_SEL) begin
            nxt_rdata[IDX_W-1:0] = wired_ff;
        end else if (cp_num == tlb_ctl_pkg::RANDOM_REG_NUM
                     && cp_sel == tlb_ctl_pkg::RANDOM_REG_SEL) begin
            nxt_rdata[IDX_W-1:0] = random_idx;
        end else if (cp_num == tlb_ctl_pkg::CFG1_REG_NUM
                     && cp_sel == tlb_ctl_pkg::CFG1_REG_SEL) begin
            nxt_rdata[tlb_ctl_pkg::CFG1_SIZE_LSB +: 6] = SIZE_M1;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cp_rdata_ff <= 32'h00000000;
        end else if (cp_rd) begin
            cp_rdata_ff <= nxt_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // entry-low write filtering
    always_comb begin
        nxt_entry = entry_wdata;
        if (!read_inhibit_enable_ff) begin
            nxt_entry[tlb_ctl_pkg::ENTRY_RI_BIT] = 1'b0;
        end
        if (!execute_inhibit_enable_ff) begin
            nxt_entry[tlb_ctl_pkg::ENTRY_XI_BIT] = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            entry_wdata_ff <= 32'h00000000;
            entry_wr_ff    <= 1'b0;
        end else begin
            entry_wr_ff <= entry_wr;
            if (entry_wr) begin
                entry_wdata_ff <= nxt_entry;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // inhibit fault codes; read inhibit takes priority
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            exc_valid_ff <= 1'b0;
            exc_code_ff  <= 5'h00;
        end else begin
            exc_valid_ff <= (ri_fault && read_inhibit_enable_ff)
                            || (xi_fault && execute_inhibit_enable_ff);
            if (!iec_ff) begin
                exc_code_ff <= tlb_ctl_pkg::TLB_LOAD_EXC_CODE;
            end else if (ri_fault && read_inhibit_enable_ff) begin
                exc_code_ff <= tlb_ctl_pkg::READ_INH_EXC_CODE;
            end else begin
                exc_code_ff <= tlb_ctl_pkg::EXEC_INH_EXC_CODE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // TLB write index; indexed has priority when both arrive
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            tlb_we_ff   <= 1'b0;
            tlb_widx_ff <= '0;
        end else begin
            tlb_we_ff <= tlb_write_indexed_op || tlb_write_random_op;
            if (tlb_write_indexed_op) begin
                tlb_widx_ff <= index_reg;
            end else if (tlb_write_random_op) begin
                tlb_widx_ff <= random_idx;
            end
        end
    end
endmodule // tlb_ctl

// ==== dv/tlb_ctl_checker.sv ====
/* assertion checker on the ports of tlb_ctl
   assumes a bind from the bench top file */
`timescale 1ns/100ps
module tlb_ctl_checker #(
    parameter int ENTRIES = 32,
    parameter int IDX_W   = 5
) (
    // clock, reset, register port
    input wire logic             mclk,
    input wire logic             rst_b,
    input wire logic             cp_wr,
    input wire logic             cp_rd,
    input wire logic [4:0]       cp_num,
    input wire logic [2:0]       cp_sel,
    input wire logic [31:0]      cp_wdata,
    input wire logic [31:0]      cp_rdata_ff,
    // filter and index paths
    input wire logic             entry_wr,
    input wire logic [31:0]      entry_wdata,
    input wire logic [31:0]      entry_wdata_ff,
    input wire logic             tlb_write_random_op,
    input wire logic             tlb_write_indexed_op,
    input wire logic [IDX_W-1:0] index_reg,
    input wire logic             tlb_we_ff,
    input wire logic [IDX_W-1:0] tlb_widx_ff,
    input wire logic             read_inhibit_enable_ff,
    input wire logic             execute_inhibit_enable_ff,
    input wire logic [IDX_W-1:0] wired_ff
);
    wire logic ac_i = cp_num == tlb_ctl_pkg::INH_REG_NUM &&
                      cp_sel == tlb_ctl_pkg::INH_REG_SEL;
    wire logic ac_w = cp_num == tlb_ctl_pkg::WIRED_REG_NUM &&
                      cp_sel == tlb_ctl_pkg::WIRED_REG_SEL;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////////////
    wired_wr_a: assert property (cp_wr && ac_w |=>
        wired_ff == $past(cp_wdata[IDX_W-1:0])) else $error("wired write");
    rie_wr_a: assert property (cp_wr && ac_i |=>
        read_inhibit_enable_ff == $past(cp_wdata[31])) else $error("rie");
    xie_wr_a: assert property (cp_wr && ac_i |=>
        execute_inhibit_enable_ff == $past(cp_wdata[30])) else $error("xie");
    ri_filter_a: assert property (entry_wr |=> entry_wdata_ff[31] ==
        ($past(entry_wdata[31]) & $past(read_inhibit_enable_ff)))
        else $error("ri filter");
    xi_filter_a: assert property (entry_wr |=> entry_wdata_ff[30] ==
        ($past(entry_wdata[30]) & $past(execute_inhibit_enable_ff)))
        else $error("xi filter");
    inh_zero_a: assert property (cp_rd && ac_i |=>
        cp_rdata_ff[29:28] == 2'h0 && cp_rdata_ff[26:0] == 27'h0)
        else $error("inhibit reserved bits");
    wired_rd_a: assert property (cp_rd && ac_w |=>
        cp_rdata_ff[31:IDX_W] == '0
        && cp_rdata_ff[IDX_W-1:0] == $past(wired_ff)) else $error("wired read");
    rnd_range_a: assert property (tlb_write_random_op &&
        !tlb_write_indexed_op |=> tlb_we_ff && tlb_widx_ff >= $past(wired_ff)
        && tlb_widx_ff <= ENTRIES - 1) else $error("random index range");
    idx_write_a: assert property (tlb_write_indexed_op |=>
        tlb_we_ff && tlb_widx_ff == $past(index_reg)) else $error("indexed");
    reset_clear_a: assert property ($rose(rst_b) |->
        wired_ff == '0 &&
        !read_inhibit_enable_ff && !execute_inhibit_enable_ff)
        else $error("reset values");
    wired_cov: cover property (cp_wr && ac_w);
    rnd_cov: cover property (tlb_write_random_op ##1 tlb_we_ff);
    ri_cov: cover property (entry_wr && read_inhibit_enable_ff);
endmodule // tlb_ctl_checker

// ==== dv/tb_top.sv ====
/* bench for tlb_ctl: register, filter, fault code and index tests
   assumes tlb_ctl_checker and the design are compiled first */
`timescale 1ns/100ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
    $display("wrong value %s exp %0h got %0h", n, e, g); end end
module tb_top;
    localparam int ENTRIES = 32;
    localparam int IDX_W   = 5;
    logic             mclk = 1'b0, rst_b = 1'b0, cp_wr = 1'b0, cp_rd = 1'b0;
    logic             entry_wr = 1'b0, ri_fault = 1'b0, xi_fault = 1'b0;
    logic             tlb_write_random_op = 1'b0, tlb_write_indexed_op = 1'b0;
    logic [4:0]       cp_num = 5'h00, exc_code_ff, ec;
    logic [2:0]       cp_sel = 3'h0;
    logic [31:0]      cp_wdata = 32'h0, entry_wdata = 32'hFFFFFFFF;
    logic [31:0]      cp_rdata_ff, entry_wdata_ff;
    logic             entry_wr_ff, exc_valid_ff, tlb_we_ff;
    logic             read_inhibit_enable_ff, execute_inhibit_enable_ff;
    logic [IDX_W-1:0] tlb_widx_ff, wired_ff, index_reg = 5'h03;
    int               fails = 0, num_checks = 0;
    tlb_ctl #(.ENTRIES(ENTRIES), .IDX_W(IDX_W)) i_dut (.mclk, .rst_b, .cp_wr,
        .cp_rd, .cp_num, .cp_sel, .cp_wdata, .cp_rdata_ff, .entry_wr,
        .entry_wdata, .entry_wdata_ff, .entry_wr_ff, .ri_fault, .xi_fault,
        .exc_valid_ff, .exc_code_ff, .tlb_write_random_op, .tlb_write_indexed_op,
        .index_reg, .tlb_we_ff, .tlb_widx_ff, .read_inhibit_enable_ff,
        .execute_inhibit_enable_ff, .wired_ff);
    ////////////////////////////////////////////////////////////////////////
    task automatic acc(input logic w, input int r, input logic [31:0] d);
        case (r)
            0: cp_num <= tlb_ctl_pkg::INH_REG_NUM;
            1: cp_num <= tlb_ctl_pkg::WIRED_REG_NUM;
            default: cp_num <= tlb_ctl_pkg::CFG1_REG_NUM;
        endcase
        cp_sel <= r == 0 ? tlb_ctl_pkg::INH_REG_SEL
                : r == 1 ? tlb_ctl_pkg::WIRED_REG_SEL : tlb_ctl_pkg::CFG1_REG_SEL;
        cp_wr <= w;
        cp_rd <= !w;
        cp_wdata <= d;
        @(posedge mclk);
        cp_wr <= 1'b0;
        cp_rd <= 1'b0;
        @(posedge mclk);
    endtask
    // bits: entry write, ri fault, xi fault, indexed op; ends off-edge
    task automatic pulse(input logic [3:0] p);
        {entry_wr, ri_fault, xi_fault, tlb_write_indexed_op} <= p;
        @(posedge mclk);
        {entry_wr, ri_fault, xi_fault, tlb_write_indexed_op} <= 4'h0;
        #1;
    endtask
    task automatic rnd_run(input logic [IDX_W-1:0] w);
        logic [IDX_W-1:0] lo;
        lo = 5'h1F;
        tlb_write_random_op <= 1'b1;
        repeat (40) begin
            @(posedge mclk);
            #1;
            if (tlb_widx_ff < lo) lo = tlb_widx_ff;
            `CHK("random op", 1'b1, tlb_we_ff && tlb_widx_ff >= w)
        end
        @(posedge mclk);
        tlb_write_random_op <= 1'b0;
        @(posedge mclk);
        `CHK("lowest random index", w, lo)
    endtask
    task automatic give_verdict;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        forever #5 mclk = ~mclk;
    end
    initial begin
        #100000;
        fails++;
        give_verdict;
    end
    initial begin
        repeat (4) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        acc(1'b0, 0, 32'h0);
        `CHK("inhibit reset", 32'h0, cp_rdata_ff)
        acc(1'b0, 2, 32'h0);
        `CHK("entry count", 6'(ENTRIES - 1), cp_rdata_ff[30:25])
        acc(1'b1, 0, 32'hC8000000);
        acc(1'b0, 0, 32'h0);
        `CHK("inhibit read", 32'hC8000000, cp_rdata_ff)
        for (int i = 0; i < 4; i++) begin
            acc(1'b1, 0, {i[1:0], 30'h0});
            pulse(4'h8);
            `CHK("entry filter", {i[1:0], 30'h3FFFFFFF}, entry_wdata_ff)
            `CHK("entry write", 1'b1, entry_wr_ff)
            @(posedge mclk);
        end
        for (int c = 0; c < 2; c++) begin
            acc(1'b1, 0, {2'h3, 2'h0, c[0], 27'h0});
            pulse(4'h4);
            ec = c ? tlb_ctl_pkg::READ_INH_EXC_CODE : tlb_ctl_pkg::TLB_LOAD_EXC_CODE;
            `CHK("ri fault code", {1'b1, ec}, {exc_valid_ff, exc_code_ff})
            @(posedge mclk);
            pulse(4'h2);
            ec = c ? tlb_ctl_pkg::EXEC_INH_EXC_CODE : tlb_ctl_pkg::TLB_LOAD_EXC_CODE;
            `CHK("xi fault code", {1'b1, ec}, {exc_valid_ff, exc_code_ff})
            @(posedge mclk);
        end
        acc(1'b0, 1, 32'h0);
        `CHK("wired reset", 32'h0, cp_rdata_ff)
        acc(1'b1, 1, 32'hFFFFFFE7);
        acc(1'b0, 1, 32'h0);
        `CHK("wired read", 32'h7, cp_rdata_ff)
        // rewrite the same boundary to fire the reload
        cp_wdata <= 32'h00000007;
        cp_wr <= 1'b1;
        @(posedge mclk);
        cp_wr <= 1'b0;
        tlb_write_random_op <= 1'b1;
        @(posedge mclk);
        tlb_write_random_op <= 1'b0;
        #1;
        `CHK("index after reload", 5'(ENTRIES - 1), tlb_widx_ff)
        @(posedge mclk);
        pulse(4'h1);
        `CHK("indexed op", {1'b1, 5'h03}, {tlb_we_ff, tlb_widx_ff})
        @(posedge mclk);
        rnd_run(5'h07);
        acc(1'b1, 1, 32'h1F);
        rnd_run(5'h1F);
        acc(1'b1, 1, 32'h0);
        rnd_run(5'h00);
        give_verdict;
    end
endmodule // tb_top
bind tlb_ctl tlb_ctl_checker #(.ENTRIES(ENTRIES), .IDX_W(IDX_W)) i_chk (
    .mclk, .rst_b, .cp_wr, .cp_rd, .cp_num, .cp_sel, .cp_wdata, .cp_rdata_ff,
    .entry_wr, .entry_wdata, .entry_wdata_ff, .tlb_write_random_op,
    .tlb_write_indexed_op, .index_reg, .tlb_we_ff, .tlb_widx_ff,
    .read_inhibit_enable_ff, .execute_inhibit_enable_ff, .wired_ff);
